// ===== pll_synth_control.sv
// Control and status logic of the fractional-N frequency synthesizer.
`timescale 1ns/100ps
`default_nettype none
module psc_pll_synth_control (
    input wire logic clk,
    input wire logic sys_rst,
    // Chip enable pin; low powers the block down.
    input wire logic chip_power_enable,
    // Comparator on the interface regulator supply, asynchronous.
    input wire logic interface_regulator_supply,
    // Programming strobe and the values it loads.
    input wire logic cfg_write,
    input wire logic osc_enable_bit,
    input wire logic [3:0] ref_out_div_sel,
    input wire logic [2:0] ref_div_ratio,
    input wire logic [2:0] status_select_field,
    input wire logic pll_enable_bit,
    input wire logic low_band_divide_bit,
    input wire logic [7:0] int_n_value,
    input wire logic [14:0] frac_n_value,
    input wire logic [1:0] vco_centre_value,
    input wire logic [3:0] vco_bias_value,
    // Phase error measurement, one strobe per comparison cycle.
    input wire logic phase_error_valid,
    input wire logic [7:0] phase_error_ns,
    output logic regulators_on,
    output logic osc_enable_out,
    output logic divided_ref_clock_out,
    output logic phase_detector_ref_pulse,
    output logic [7:0] fb_int_value,
    output logic [14:0] fb_frac_value,
    output logic [8:0] fb_divide_value,
    output logic int_setting_invalid,
    output logic vco_enable,
    output logic [1:0] vco_centre_out,
    output logic [3:0] vco_bias_out,
    output logic [2:0] out_divide_ratio,
    output logic [2:0] ref_ratio_out,
    output logic regulator_ready,
    output logic digital_lock,
    output logic analog_lock_o,
    output logic analog_lock_oe,
    output logic status_mux_o,
    output logic status_mux_oe
);
    import psc_pkg::*;

    // Clamps an out-of-range reference ratio so the divider never stalls.
    function automatic logic [2:0] eff_ratio(input logic [2:0] r);
        eff_ratio = (r == 3'h0) ? 3'h1 : r;
    endfunction

    // Pin synchronisers.
    logic ce_meta_q;
    logic ce_sync_q;
    logic rdy_meta_q;
    logic rdy_sync_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ce_meta_q <= 1'b0;
            ce_sync_q <= 1'b0;
        end else begin
            ce_meta_q <= chip_power_enable;
            ce_sync_q <= ce_meta_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdy_meta_q <= 1'b0;
            rdy_sync_q <= 1'b0;
        end else begin
            rdy_meta_q <= interface_regulator_supply;
            rdy_sync_q <= rdy_meta_q;
        end
    end

    logic pd_q;
    logic reg_ready;

    assign pd_q = sys_rst || !ce_sync_q;
    assign regulators_on = ce_sync_q;
    assign reg_ready = ce_sync_q && rdy_sync_q;

    // Programmed values. Power-down returns every one to its default, and
    // writes are ignored while the interface supply is not yet stable.
    logic osc_en_q;
    logic [3:0] ref_out_div_q;
    logic [2:0] ref_div_q;
    logic [2:0] status_sel_q;
    logic pll_en_q;
    logic low_band_q;
    logic [7:0] int_n_q;
    logic [14:0] frac_n_q;
    logic [1:0] vco_centre_q;
    logic [3:0] vco_bias_q;

    always_ff @(posedge clk) begin
        if (pd_q) begin
            osc_en_q <= OSC_EN_RESET;
            ref_out_div_q <= REF_OUT_DIV_RESET;
            ref_div_q <= REF_DIV_RESET;
            status_sel_q <= STATUS_SEL_RESET;
            pll_en_q <= 1'b0;
            low_band_q <= 1'b0;
            int_n_q <= INT_N_RESET;
            frac_n_q <= FRAC_N_RESET;
            vco_centre_q <= VCO_CENTRE_RESET;
            vco_bias_q <= VCO_BIAS_RESET;
        end else if (cfg_write && reg_ready) begin
            osc_en_q <= osc_enable_bit;
            ref_out_div_q <= ref_out_div_sel;
            ref_div_q <= ref_div_ratio;
            status_sel_q <= status_select_field;
            pll_en_q <= pll_enable_bit;
            low_band_q <= low_band_divide_bit;
            int_n_q <= int_n_value;
            frac_n_q <= frac_n_value;
            vco_centre_q <= vco_centre_value;
            vco_bias_q <= vco_bias_value;
        end
    end

    assign osc_enable_out = osc_en_q && ce_sync_q;

    // Divided reference clock output; the field holds half the divide.
    psc_even_div #(
        .SEL_W(4)
    ) u_ref_out_div (
        .clk(clk),
        .rst(pd_q),
        .enable(1'b1),
        .half_period(ref_out_div_q),
        .clk_out(divided_ref_clock_out)
    );

    // Reference divider: one pulse every R crystal cycles is the comparison
    // clock. A ratio of zero is treated as one rather than stopping the loop.
    logic [2:0] r_cnt_q;
    logic ref_pulse_q;

    always_ff @(posedge clk) begin
        if (pd_q) begin
            r_cnt_q <= 3'h0;
            ref_pulse_q <= 1'b0;
        end else if (r_cnt_q >= eff_ratio(ref_div_q) - 3'h1) begin
            r_cnt_q <= 3'h0;
            ref_pulse_q <= 1'b1;
        end else begin
            r_cnt_q <= r_cnt_q + 3'h1;
            ref_pulse_q <= 1'b0;
        end
    end

    assign phase_detector_ref_pulse = ref_pulse_q;
    assign ref_ratio_out = eff_ratio(ref_div_q);

    // First-order sigma-delta: the fraction accumulates once per comparison
    // cycle and each overflow adds one to the integer divide for that cycle,
    // so the mean divide is the integer plus the fraction over 2^15.
    logic [14:0] acc_q;
    logic [15:0] acc_sum;
    logic carry_q;
    logic [7:0] int_eff;
    logic [8:0] div_q;

    assign acc_sum = {1'b0, acc_q} + {1'b0, frac_n_q};
    // Settings below the pulse-swallow minimum are flagged and held at it.
    assign int_setting_invalid = int_n_q < INT_N_MIN;
    assign int_eff = int_setting_invalid ? INT_N_MIN : int_n_q;

    always_ff @(posedge clk) begin
        if (pd_q || !pll_en_q) begin
            acc_q <= 15'h0000;
            carry_q <= 1'b0;
            div_q <= 9'h000;
        end else if (ref_pulse_q) begin
            acc_q <= acc_sum[14:0];
            carry_q <= acc_sum[15];
            div_q <= {1'b0, int_eff} + {8'h00, acc_sum[15]};
        end
    end

    assign fb_int_value = int_eff;
    assign fb_frac_value = frac_n_q;
    assign fb_divide_value = div_q;

    // VCO controls.
    assign vco_enable = pll_en_q && ce_sync_q;
    assign vco_centre_out = vco_centre_q;
    assign vco_bias_out = vco_bias_q;
    assign out_divide_ratio =
        low_band_q ? VCO_DIV_LOW_BAND : VCO_DIV_BASE;

    // Digital lock detect. Measurements only count while the loop runs.
    psc_lock_state_t lock_state_q;
    logic [2:0] good_cnt_q;

    always_ff @(posedge clk) begin
        if (pd_q || !pll_en_q) begin
            lock_state_q <= LOCK_SEARCH;
            good_cnt_q <= 3'h0;
        end else if (phase_error_valid) begin
            case (lock_state_q)
                LOCK_SEARCH: begin
                    if (phase_error_ns < LOCK_SET_ERR_NS) begin
                        if (good_cnt_q == LOCK_GOOD_CYCLES - 3'h1) begin
                            lock_state_q <= LOCK_HELD;
                            good_cnt_q <= 3'h0;
                        end else begin
                            good_cnt_q <= good_cnt_q + 3'h1;
                        end
                    end else begin
                        good_cnt_q <= 3'h0;
                    end
                end
                LOCK_HELD: begin
                    // The wider release threshold keeps the flag from
                    // chattering on errors between the two limits.
                    if (phase_error_ns >= LOCK_CLEAR_ERR_NS) begin
                        lock_state_q <= LOCK_SEARCH;
                    end
                    good_cnt_q <= 3'h0;
                end
                default: begin
                    lock_state_q <= LOCK_SEARCH;
                    good_cnt_q <= 3'h0;
                end
            endcase
        end
    end

    logic locked;

    assign locked = lock_state_q == LOCK_HELD;
    assign digital_lock = locked;

    // Analog lock detect: released high while locked, with a one-cycle low
    // pulse on each comparison clock; pulled low otherwise.
    logic ana_high;

    assign ana_high = locked && !ref_pulse_q;
    assign analog_lock_o = 1'b0;
    assign analog_lock_oe = !ana_high;

    // Status multiplexer. Push-pull except on the analog lock choice, where
    // it behaves as the open-drain signal and needs the external pull-up.
    logic mux_val;

    assign regulator_ready = reg_ready;

    always_comb begin
        mux_val = 1'b0;
        case (status_sel_q)
            MUX_REG_READY: mux_val = reg_ready;
            MUX_DIG_LOCK: mux_val = locked;
            MUX_ANA_LOCK: mux_val = 1'b0;
            MUX_REF_PULSE: mux_val = ref_pulse_q;
            MUX_FRAC_CARRY: mux_val = carry_q;
            MUX_HIGH: mux_val = 1'b1;
            MUX_LOW: mux_val = 1'b0;
            default: mux_val = 1'b0;
        endcase
    end

    assign status_mux_o = mux_val;
    assign status_mux_oe =
        (status_sel_q == MUX_ANA_LOCK) ? !ana_high : 1'b1;
endmodule
`default_nettype wire

// ===== psc_pkg.sv
// Constants and types shared by the synthesizer control logic.
package psc_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int REG_UP_TIME_US = 50;
    localparam int REG_UP_CYCLES =
        (REG_UP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [3:0] REF_OUT_DIV_RESET = 4'h4;
    localparam logic [2:0] REF_DIV_RESET = 3'h1;
    localparam logic [2:0] STATUS_SEL_RESET = 3'h0;
    localparam logic OSC_EN_RESET = 1'b1;
    localparam logic [7:0] INT_N_RESET = 8'h00;
    localparam logic [14:0] FRAC_N_RESET = 15'h0000;
    localparam logic [1:0] VCO_CENTRE_RESET = 2'h0;
    localparam logic [3:0] VCO_BIAS_RESET = 4'h0;
    localparam logic [7:0] INT_N_MIN = 8'h1F;

    localparam logic [7:0] LOCK_SET_ERR_NS = 8'h0F;
    localparam logic [7:0] LOCK_CLEAR_ERR_NS = 8'h19;
    localparam logic [2:0] LOCK_GOOD_CYCLES = 3'h5;

    localparam logic [2:0] VCO_DIV_BASE = 3'h2;
    localparam logic [2:0] VCO_DIV_LOW_BAND = 3'h4;

    localparam logic [2:0] MUX_REG_READY = 3'h0;
    localparam logic [2:0] MUX_DIG_LOCK = 3'h1;
    localparam logic [2:0] MUX_ANA_LOCK = 3'h2;
    localparam logic [2:0] MUX_REF_PULSE = 3'h3;
    localparam logic [2:0] MUX_FRAC_CARRY = 3'h4;
    localparam logic [2:0] MUX_HIGH = 3'h5;
    localparam logic [2:0] MUX_LOW = 3'h6;

    typedef enum logic [1:0] {
        LOCK_SEARCH = 2'b01,
        LOCK_HELD = 2'b10
    } psc_lock_state_t;
endpackage

// ===== psc_even_div.sv
// Even clock divider producing a square wave from the crystal clock.
`timescale 1ns/100ps
`default_nettype none
module psc_even_div #(
    parameter int SEL_W = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [SEL_W-1:0] half_period,
    output logic clk_out
);
    logic [SEL_W-1:0] cnt_q;
    logic out_q;

    // Toggling every half_period cycles gives a 50:50 output of twice that.
    always_ff @(posedge clk) begin
        if (rst || !enable || half_period == '0) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else if (cnt_q >= half_period - 1'b1) begin
            cnt_q <= '0;
            out_q <= ~out_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign clk_out = out_q;
endmodule
`default_nettype wire

// ===== psc_props.sv
// Concurrent checks on the synthesizer control ports.
`timescale 1ns/100ps
`default_nettype none
module psc_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic phase_error_valid,
    input wire logic [7:0] phase_error_ns,
    input wire logic regulators_on,
    input wire logic osc_enable_out,
    input wire logic divided_ref_clock_out,
    input wire logic phase_detector_ref_pulse,
    input wire logic [7:0] fb_int_value,
    input wire logic int_setting_invalid,
    input wire logic vco_enable,
    input wire logic [2:0] out_divide_ratio,
    input wire logic [2:0] ref_ratio_out,
    input wire logic regulator_ready,
    input wire logic digital_lock,
    input wire logic analog_lock_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_osc_needs_power: assert property (osc_enable_out |-> regulators_on)
        else $error("oscillator on while powered down");
    a_vco_needs_power: assert property (vco_enable |-> regulators_on)
        else $error("vco on while powered down");
    a_ready_needs_power: assert property (regulator_ready |-> regulators_on)
        else $error("regulator ready while powered down");
    a_int_clamp_low: assert property (
        int_setting_invalid |-> fb_int_value == 8'h1F)
        else $error("invalid integer not clamped");
    a_vco_div_ratio: assert property (
        out_divide_ratio == 3'h2 || out_divide_ratio == 3'h4)
        else $error("bad vco output ratio");
    a_ref_pulse_single: assert property (
        phase_detector_ref_pulse && ref_ratio_out != 3'h1
        |=> !phase_detector_ref_pulse)
        else $error("reference pulse too long");
    a_lock_set_cause: assert property ($rose(digital_lock) |->
        $past(phase_error_valid) && $past(phase_error_ns) < 8'h0F)
        else $error("lock set without a small error");
    a_lock_clear_big: assert property (
        digital_lock && phase_error_valid && phase_error_ns >= 8'h19
        |=> !digital_lock)
        else $error("lock kept after a large error");
    a_analog_open_drain: assert property (analog_lock_o == 1'b0)
        else $error("analog lock drives high");
    c_lock_set: cover property ($rose(digital_lock));
    c_lock_clear: cover property ($fell(digital_lock));
    c_ref_out_edge: cover property ($rose(divided_ref_clock_out));
endmodule
`default_nettype wire

// ===== psc_host_model.sv
// Host controller model that issues programming strobes.
`timescale 1ns/100ps
`default_nettype none
module psc_host_model (
    input wire logic clk,
    input wire logic regulator_ready,
    input wire logic req,
    output logic cfg_write,
    output logic [3:0] vco_bias_value,
    output logic [1:0] vco_centre_value
);
    // Bias below 8 may not oscillate, so the host never programs less.
    assign vco_bias_value = 4'h8;
    assign vco_centre_value = 2'h1;
    initial cfg_write = 1'b0;
    // Writes wait for the interface supply; a held request strobes every other cycle.
    always @(negedge clk) begin
        cfg_write <= req && regulator_ready && !cfg_write;
    end
endmodule
`default_nettype wire

// ===== pll_synth_control_tb.sv
// Self-checking testbench for the synthesizer control logic.
`timescale 1ns/100ps
`default_nettype none
bind psc_pll_synth_control psc_props u_props (.clk, .sys_rst,
    .phase_error_valid, .phase_error_ns, .regulators_on, .osc_enable_out,
    .divided_ref_clock_out, .phase_detector_ref_pulse, .fb_int_value,
    .int_setting_invalid, .vco_enable, .out_divide_ratio, .ref_ratio_out,
    .regulator_ready, .digital_lock, .analog_lock_o);
module pll_synth_control_tb;
    logic clk = 0, sys_rst = 1, chip_power_enable = 1, req = 0;
    logic interface_regulator_supply = 1, osc_enable_bit = 1;
    logic pll_enable_bit = 0, low_band_divide_bit = 0, phase_error_valid = 0;
    logic [3:0] ref_out_div_sel = 4'h4, vco_bias_value, vco_bias_out;
    logic [2:0] ref_div_ratio = 3'h1, status_select_field = 3'h0;
    logic [7:0] int_n_value = 8'h20, phase_error_ns = 8'h00, fb_int_value;
    logic [14:0] frac_n_value = 15'h0000, fb_frac_value;
    logic [1:0] vco_centre_value, vco_centre_out;
    logic [2:0] out_divide_ratio, ref_ratio_out;
    logic [8:0] fb_divide_value;
    logic cfg_write, regulators_on, osc_enable_out, divided_ref_clock_out;
    logic phase_detector_ref_pulse, int_setting_invalid, vco_enable;
    logic regulator_ready, digital_lock, analog_lock_o, analog_lock_oe;
    logic status_mux_o, status_mux_oe;
    int n_fail = 0, compares = 0, n;
    always #12.5 clk = ~clk;
    psc_host_model host (.clk, .regulator_ready, .req, .cfg_write,
        .vco_bias_value, .vco_centre_value);
    psc_pll_synth_control dut (.clk, .sys_rst, .chip_power_enable,
        .interface_regulator_supply, .cfg_write, .osc_enable_bit,
        .ref_out_div_sel, .ref_div_ratio, .status_select_field,
        .pll_enable_bit, .low_band_divide_bit, .int_n_value, .frac_n_value,
        .vco_centre_value, .vco_bias_value, .phase_error_valid,
        .phase_error_ns, .regulators_on, .osc_enable_out,
        .divided_ref_clock_out, .phase_detector_ref_pulse, .fb_int_value,
        .fb_frac_value, .fb_divide_value, .int_setting_invalid, .vco_enable,
        .vco_centre_out, .vco_bias_out, .out_divide_ratio, .ref_ratio_out,
        .regulator_ready, .digital_lock, .analog_lock_o, .analog_lock_oe,
        .status_mux_o, .status_mux_oe);
    task automatic tally_and_finish();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_ready();
        for (int k = 0; k < 200 && regulator_ready !== 1'b1; k++)
            @(negedge clk);
    endtask
    // Writes go through the host model, which refuses until ready.
    task automatic wr();
        req <= 1'b1;
        for (int k = 0; k < 300 && cfg_write !== 1'b1; k++) @(posedge clk);
        @(negedge clk);
        req <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic hi_len(output int len);
        len = 0;
        for (int k = 0; k < 99 && divided_ref_clock_out; k++) @(negedge clk);
        for (int k = 0; k < 99 && !divided_ref_clock_out; k++) @(negedge clk);
        for (int k = 0; k < 99 && divided_ref_clock_out; k++) begin
            @(negedge clk);
            len++;
        end
    endtask
    task automatic gap(output int len);
        len = 0;
        for (int k = 0; k < 99 && !phase_detector_ref_pulse; k++)
            @(negedge clk);
        do begin
            @(negedge clk);
            len++;
        end while (!phase_detector_ref_pulse && len < 99);
    endtask
    task automatic err(input logic [7:0] e);
        @(negedge clk);
        phase_error_valid <= 1'b1;
        phase_error_ns <= e;
        @(negedge clk);
        phase_error_valid <= 1'b0;
    endtask
    task automatic t_defaults();
        wait_ready();
        chk(regulator_ready, 1);
        chk(status_mux_o, 1);
        chk(ref_ratio_out, 1);
        chk(osc_enable_out, 1);
        chk(out_divide_ratio, 2);
        hi_len(n);
        chk(n, 4);
    endtask
    task automatic t_dividers();
        ref_out_div_sel = 4'h1;
        ref_div_ratio = 3'h7;
        wr();
        hi_len(n);
        chk(n, 1);
        gap(n);
        chk(n, 7);
        ref_out_div_sel = 4'hF;
        wr();
        hi_len(n);
        chk(n, 15);
        ref_out_div_sel = 4'h0;
        wr();
        hi_len(n);
        chk(n, 0);
    endtask
    task automatic t_vco_mux();
        pll_enable_bit = 1'b1;
        low_band_divide_bit = 1'b1;
        int_n_value = 8'h0A;
        frac_n_value = 15'h1234;
        status_select_field = 3'h5;
        wr();
        chk(vco_enable, 1);
        chk(out_divide_ratio, 4);
        chk(fb_int_value, 31);
        chk(fb_frac_value, 15'h1234);
        chk(vco_bias_out, 8);
        chk(status_mux_o, 1);
        chk(vco_centre_out, 1);
        chk(int_setting_invalid, 1);
        // At most two comparison cycles have passed, too few for a carry.
        repeat (8) @(negedge clk);
        chk(fb_divide_value, 31);
        status_select_field = 3'h6;
        wr();
        chk(status_mux_o, 0);
        // A near-full fraction carries on every cycle once the accumulator is nonzero.
        frac_n_value = 15'h7FFF;
        status_select_field = 3'h4;
        wr();
        repeat (10) @(negedge clk);
        chk(fb_divide_value, 32);
        chk(status_mux_o, 1);
    endtask
    task automatic t_lock();
        status_select_field = 3'h2;
        wr();
        chk(status_mux_oe, 1);
        chk(status_mux_o, 0);
        chk(analog_lock_oe, 1);
        repeat (4) err(8'h0A);
        err(8'h14);
        repeat (4) err(8'h0A);
        @(negedge clk);
        chk(digital_lock, 0);
        err(8'h0A);
        @(negedge clk);
        chk(digital_lock, 1);
        // Locked: both pins pull low for one cycle in every seven.
        n = 0;
        repeat (7) begin
            @(negedge clk);
            n += analog_lock_oe + status_mux_oe;
        end
        chk(n, 2);
        err(8'h18);
        @(negedge clk);
        chk(digital_lock, 1);
        err(8'h19);
        @(negedge clk);
        chk(digital_lock, 0);
    endtask
    task automatic t_power_down();
        // External reference: the host stops the oscillator.
        osc_enable_bit = 1'b0;
        wr();
        chk(osc_enable_out, 0);
        chip_power_enable <= 1'b0;
        repeat (5) @(negedge clk);
        chk(regulators_on, 0);
        chk(regulator_ready, 0);
        chk(osc_enable_out, 0);
        chk(vco_enable, 0);
        chip_power_enable <= 1'b1;
        wait_ready();
        chk(ref_ratio_out, 1);
        chk(out_divide_ratio, 2);
        chk(regulator_ready, 1);
        chk(osc_enable_out, 1);
        chk(vco_enable, 0);
        chk(vco_centre_out, 0);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        sys_rst <= 1'b0;
        t_defaults();
        t_dividers();
        t_vco_mux();
        t_lock();
        t_power_down();
        tally_and_finish();
    end
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
